// ---- src/luca_map.svh ----
// Address map, field positions, reset values and timing counts of the
// line unit control and alarm block.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one word a register.
`ifndef LUCA_MAP_SVH
`define LUCA_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define LUCA_OFS_CTRL     4'h0
`define LUCA_OFS_STATUS   4'h4
`define LUCA_OFS_MASK     4'h8
`define LUCA_OFS_LIVE     4'hc

// ****************************************************************
// Field bases, four bits each, one bit a channel, except the single host bit
// ****************************************************************
`define LUCA_F_RAIL       0
`define LUCA_F_AONES      4
`define LUCA_F_LLB        8
`define LUCA_F_RLB        12
`define LUCA_F_DFAIL      0
`define LUCA_F_LOS        4
`define LUCA_F_LOL        8
`define LUCA_F_LCV        12
`define LUCA_F_HOST       16
`define LUCA_EV_W         16

// ****************************************************************
// Reset values
// ****************************************************************
`define LUCA_RST_CTRL     32'h0000_0000
`define LUCA_RST_MASK     16'h0000

// ****************************************************************
// Timing counts
// ****************************************************************
`define LUCA_DMO_PERIODS  128
`define LUCA_LOS_E3       32
`define LUCA_LOS_DS3_HI   175
`define LUCA_LOS_DS3_LO   100
`define LUCA_LOL_WINDOW   1024
`define LUCA_LOL_PERMILLE 5

`endif

// ---- src/luca_pkg.sv ----
// Types shared by the line unit control and alarm block.
// Assumes nothing of its surroundings.
package luca_pkg;

   // Loop-back path of one channel
   typedef enum logic [1:0] {
      LUCA_LOOP_NONE,
      LUCA_LOOP_ANALOG,
      LUCA_LOOP_DIGITAL,
      LUCA_LOOP_REMOTE
   } luca_loop_t;

endpackage : luca_pkg

// ---- src/luca_chan.sv ----
// One line channel: drive monitor, all-ones generator, loop-back paths,
// zero-substitution decoder with violation flag, signal and lock alarms.
// Assumes clocks from the line side arrive as levels synchronous to clk_sys
// and much slower than it; edges are found by comparing with the last sample.
`timescale 1ns/1ps
`default_nettype none
`include "luca_map.svh"

module luca_chan (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               e3_mode,
   input  wire logic               thr_sel,
   input  wire logic               single_rail,
   input  wire logic               all_ones,
   input  wire luca_pkg::luca_loop_t loop_mode,
   input  wire logic               tx_clk_in,
   input  wire logic               tx_pos_in,
   input  wire logic               tx_neg_in,
   input  wire logic               mon_tip,
   input  wire logic               mon_ring,
   input  wire logic               rx_clk_in,
   input  wire logic               rx_pos_in,
   input  wire logic               rx_neg_in,
   input  wire logic               ref_clk_in,
   output logic                    drive_fail,
   output logic                    line_tip,
   output logic                    line_ring,
   output logic                    rx_pos_out,
   output logic                    rx_neg_out,
   output logic                    los,
   output logic                    lol,
   output logic                    lcv_pulse
);
   import luca_pkg::*;

   localparam int LOL_TOL = (`LUCA_LOL_WINDOW * `LUCA_LOL_PERMILLE) / 1000;

   logic       txc_prev_reg, rxc_prev_reg, refc_prev_reg;
   logic       tx_edge, rx_edge, ref_edge, lb_clk;
   logic       sel_rx_pos, sel_rx_neg, sel_tx_pos, sel_tx_neg;
   logic       ami_pol_reg;
   logic [7:0] dmo_cnt_reg;
   logic [7:0] los_cnt_reg;
   logic [7:0] los_limit;
   logic [1:0] sym_reg [3];
   logic       pol_reg;
   logic       in_pulse, is_viol, sub3, sub2;
   logic [10:0] lol_ref_reg, lol_rx_reg;

   // Edge finding on the line-side clocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txc_prev_reg  <= 1'b0;
         rxc_prev_reg  <= 1'b0;
         refc_prev_reg <= 1'b0;
      end else begin
         txc_prev_reg  <= tx_clk_in;
         rxc_prev_reg  <= rx_clk_in;
         refc_prev_reg <= ref_clk_in;
      end
   end
   assign tx_edge  = tx_clk_in & ~txc_prev_reg;
   assign ref_edge = ref_clk_in & ~refc_prev_reg;
   // Loop-backs that feed the receiver from transmit run on the transmit clock
   assign lb_clk   = (loop_mode == LUCA_LOOP_ANALOG || loop_mode == LUCA_LOOP_DIGITAL) ? tx_edge : 1'b0;
   assign rx_edge  = (loop_mode == LUCA_LOOP_ANALOG || loop_mode == LUCA_LOOP_DIGITAL) ? lb_clk
                   : rx_clk_in & ~rxc_prev_reg;

   // Receive source per loop mode
   always_comb begin
      sel_rx_pos = rx_pos_in;
      sel_rx_neg = rx_neg_in;
      sel_tx_pos = tx_pos_in;
      sel_tx_neg = tx_neg_in;
      case (loop_mode)
         LUCA_LOOP_ANALOG: begin
            sel_rx_pos = line_tip;
            sel_rx_neg = line_ring;
         end
         LUCA_LOOP_DIGITAL: begin
            sel_rx_pos = tx_pos_in;
            sel_rx_neg = tx_neg_in;
         end
         LUCA_LOOP_REMOTE: begin
            sel_tx_pos = rx_pos_in;
            sel_tx_neg = rx_neg_in;
         end
         default: begin
            sel_rx_pos = rx_pos_in;
         end
      endcase
   end

   // Line driver; remote loop is paced by the recovered clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_tip    <= 1'b0;
         line_ring   <= 1'b0;
         ami_pol_reg <= 1'b0;
      end else if (loop_mode == LUCA_LOOP_REMOTE) begin
         if (rx_clk_in & ~rxc_prev_reg) begin
            line_tip  <= sel_tx_pos;
            line_ring <= sel_tx_neg;
         end
      end else if (tx_edge) begin
         if (all_ones) begin
            line_tip    <= ~ami_pol_reg;
            line_ring   <= ami_pol_reg;
            ami_pol_reg <= ~ami_pol_reg;
         end else begin
            line_tip  <= sel_tx_pos;
            line_ring <= sel_tx_neg;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dmo_cnt_reg <= 8'h00;
         drive_fail  <= 1'b0;
      end else if (mon_tip ^ mon_ring) begin
         dmo_cnt_reg <= 8'h00;
         drive_fail  <= 1'b0;
      end else if (tx_edge && !drive_fail) begin
         if (dmo_cnt_reg == 8'(`LUCA_DMO_PERIODS - 1)) begin
            drive_fail <= 1'b1;
         end
         dmo_cnt_reg <= dmo_cnt_reg + 8'h01;
      end
   end

   always_comb begin
      if (e3_mode) begin
         los_limit = 8'(`LUCA_LOS_E3);
      end else if (thr_sel) begin
         los_limit = 8'(`LUCA_LOS_DS3_HI);
      end else begin
         los_limit = 8'(`LUCA_LOS_DS3_LO);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         los_cnt_reg <= 8'h00;
         los         <= 1'b0;
      end else if (rx_edge) begin
         if (sel_rx_pos | sel_rx_neg) begin
            los_cnt_reg <= 8'h00;
            los         <= 1'b0;
         end else if (los_cnt_reg >= los_limit - 8'h01) begin
            los <= 1'b1;
         end else begin
            los_cnt_reg <= los_cnt_reg + 8'h01;
         end
      end
   end

   // frequency compare over a reference window
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lol_ref_reg <= 11'h000;
         lol_rx_reg  <= 11'h000;
         lol         <= 1'b0;
      end else if (ref_edge && lol_ref_reg == 11'(`LUCA_LOL_WINDOW - 1)) begin
         lol         <= (lol_rx_reg > 11'(`LUCA_LOL_WINDOW + LOL_TOL)) ||
                        (lol_rx_reg < 11'(`LUCA_LOL_WINDOW - LOL_TOL));
         lol_ref_reg <= 11'h000;
         lol_rx_reg  <= {10'h000, rx_edge};
      end else begin
         lol_ref_reg <= lol_ref_reg + {10'h000, ref_edge};
         if (rx_edge && lol_rx_reg != 11'h7ff) begin
            lol_rx_reg <= lol_rx_reg + 11'h001;
         end
      end
   end

   // Violation and substitution pattern checks
   assign in_pulse = sel_rx_pos | sel_rx_neg;
   assign is_viol  = in_pulse && (sel_rx_pos == pol_reg);
   assign sub2     = (sym_reg[0] == 2'b00) && (sym_reg[1] == 2'b00);
   assign sub3     = !e3_mode && (sym_reg[0] == 2'b00) && (sym_reg[1] != 2'b00);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sym_reg[0] <= 2'b00;
         sym_reg[1] <= 2'b00;
         sym_reg[2] <= 2'b00;
         pol_reg    <= 1'b0;
         rx_pos_out <= 1'b0;
         rx_neg_out <= 1'b0;
         lcv_pulse  <= 1'b0;
      end else if (rx_edge) begin
         if (in_pulse) begin
            pol_reg <= sel_rx_pos;
         end
         sym_reg[0] <= {sel_rx_pos, sel_rx_neg};
         sym_reg[1] <= sym_reg[0];
         sym_reg[2] <= sym_reg[1];
         lcv_pulse  <= 1'b0;
         if (single_rail && is_viol) begin
            if (sub2 || sub3) begin
               // Substitution pattern found: restore zeros
               sym_reg[0] <= 2'b00;
               sym_reg[2] <= 2'b00;
            end else begin
               lcv_pulse <= 1'b1;
            end
         end
         if (single_rail) begin
            rx_pos_out <= |sym_reg[2];
            rx_neg_out <= is_viol && !sub2 && !sub3;
         end else begin
            rx_pos_out <= sym_reg[2][1];
            rx_neg_out <= sym_reg[2][0];
         end
      end else begin
         lcv_pulse <= 1'b0;
      end
   end

endmodule : luca_chan
`default_nettype wire

// ---- src/luca_top.sv ----
// Four-channel control and alarm logic of a line interface unit, with an
// Avalon-MM register slave, sticky event status and one interrupt.
// Assumes all pins sampled synchronous to clk_sys; straps steady in use.
//
// Notes on behaviour
// - No monitor pulse for 128 transmit periods raises drive fail until next pulse.
// - All-ones select high makes the channel send AMI ones on its transmit clock, except in remote loop-back.
// - Host mode ignores all-ones select pin; system ties it low.
// - Loss-of-signal output rises on signal loss; criteria differ E3 against DS3.
// - Loss-of-lock rises when recovered clock strays over 0.5% from reference.
// - Hardware single-rail enables decoder, violation shown on negative rail pin.
// - Host single-rail bit set to one does the same per channel.
// - Decoder strips 00V, 000V, B0V (not at E3) patterns and the V of B00V (its B still passes), giving zeros instead.
// - In-circuit test low tri-states all outputs; system holds it high.
// - Threshold select counts only at DS3 or STS-1 rate, not at E3.
// - Local high, remote low gives analog local loop-back.
// - Local and remote both high gives digital local loop-back.
// - Remote high, local low gives remote loop-back.
// - Host mode ignores loop select pins; system ties them low.
// - Select high is host mode with rail, all-ones and loop pins ignored (E3 and threshold pins still act); low is hardware.
`timescale 1ns/1ps
`default_nettype none
`include "luca_map.svh"

module luca_top #(
   parameter int NCH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic [31:0]           avs_readdata,
   output logic                  avs_waitrequest,
   output logic                  irq,
   // Straps and mode pins
   input  wire logic             select_a,
   input  wire logic             incircuit_test_n,
   input  wire logic             signal_threshold_sel,
   input  wire logic             rail_mode_sel,
   input  wire logic [NCH-1:0]   e3_mode_sel,
   input  wire logic [NCH-1:0]   all_ones_select,
   input  wire logic [NCH-1:0]   local_loop_sel,
   input  wire logic [NCH-1:0]   remote_loop_sel,
   // Line side
   input  wire logic [NCH-1:0]   tx_line_clock,
   input  wire logic [NCH-1:0]   tx_pos_data,
   input  wire logic [NCH-1:0]   tx_neg_data,
   input  wire logic [NCH-1:0]   monitor_tip_in,
   input  wire logic [NCH-1:0]   monitor_ring_in,
   input  wire logic [NCH-1:0]   rx_line_clock,
   input  wire logic [NCH-1:0]   rx_line_pos,
   input  wire logic [NCH-1:0]   rx_line_neg,
   input  wire logic [NCH-1:0]   reference_clock_in,
   output logic [NCH-1:0]        line_out_tip,
   output logic [NCH-1:0]        line_out_ring,
   output logic [NCH-1:0]        rx_positive_rail,
   output logic [NCH-1:0]        rx_negative_rail,
   output logic [NCH-1:0]        drive_fail_flag,
   output logic [NCH-1:0]        signal_loss_out,
   output logic [NCH-1:0]        lock_loss_out,
   output logic                  pins_oe_n
);
   import luca_pkg::*;

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // Register fields hold four channels each
   if (NCH < 1 || NCH > 4) begin : g_bad_nch
      $error("NCH must lie between 1 and 4");
   end

   logic [31:0]            ctrl_reg;
   logic [`LUCA_EV_W-1:0]  status_reg, status_next;
   logic [`LUCA_EV_W-1:0]  mask_reg;
   logic [`LUCA_EV_W-1:0]  ev_set, ev_clr, live;
   logic                   ack_reg;
   logic                   wr_take, rd_take;
   logic [31:0]            rd_mux;
   logic [NCH-1:0]         dfail_w, los_w, lol_w, lcv_w;
   logic [NCH-1:0]         dfail_d_reg, los_d_reg, lol_d_reg;

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   // One wait cycle: answer the edge after a request is seen
   assign wr_take = avs_write & ack_reg;
   assign rd_take = avs_read & ~ack_reg;

   // Acknowledge toggles once per request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_reg         <= (avs_read | avs_write) & ~ack_reg;
         avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg);
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `LUCA_OFS_CTRL:   rd_mux = ctrl_reg;
         `LUCA_OFS_STATUS: rd_mux = {16'h0000, status_reg};
         `LUCA_OFS_MASK:   rd_mux = {16'h0000, mask_reg};
         `LUCA_OFS_LIVE:   rd_mux = {15'h0000, select_a, live};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data stands from the answering edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_take) begin
         avs_readdata <= rd_mux;
      end
   end

   // Control word, low two byte lanes honoured
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `LUCA_RST_CTRL;
      end else if (wr_take && avs_address == `LUCA_OFS_CTRL) begin
         for (int b = 0; b < 2; b++) begin
            if (avs_byteenable[b]) begin
               ctrl_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
            end
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= `LUCA_RST_MASK;
      end else if (wr_take && avs_address == `LUCA_OFS_MASK) begin
         for (int b = 0; b < 2; b++) begin
            if (avs_byteenable[b]) begin
               mask_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
            end
         end
      end
   end

   // ****************************************************************
   // Events and interrupt
   // ****************************************************************
   // Rising alarms and each violation set sticky bits
   always_comb begin
      ev_set = '0;
      live   = '0;
      ev_clr = '0;
      ev_set[`LUCA_F_DFAIL +: NCH] = dfail_w & ~dfail_d_reg;
      ev_set[`LUCA_F_LOS +: NCH]   = los_w & ~los_d_reg;
      ev_set[`LUCA_F_LOL +: NCH]   = lol_w & ~lol_d_reg;
      ev_set[`LUCA_F_LCV +: NCH]   = lcv_w;
      live[`LUCA_F_DFAIL +: NCH]   = dfail_w;
      live[`LUCA_F_LOS +: NCH]     = los_w;
      live[`LUCA_F_LOL +: NCH]     = lol_w;
      if (wr_take && avs_address == `LUCA_OFS_STATUS) begin
         ev_clr = avs_writedata[`LUCA_EV_W-1:0];
      end
      // Set beats clear so no event is lost
      status_next = (status_reg & ~ev_clr) | ev_set;
   end

   // Sticky status, edge history and level interrupt
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_reg  <= '0;
         dfail_d_reg <= '0;
         los_d_reg   <= '0;
         lol_d_reg   <= '0;
         irq         <= 1'b0;
      end else begin
         status_reg  <= status_next;
         dfail_d_reg <= dfail_w;
         los_d_reg   <= los_w;
         lol_d_reg   <= lol_w;
         irq         <= |(status_next & mask_reg);
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // test input floats pins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins_oe_n <= 1'b1;
      end else begin
         pins_oe_n <= ~incircuit_test_n;
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      logic       host;
      logic       single;
      logic       aones;
      logic       llb, rlb;
      luca_loop_t mode;

      assign host   = select_a;
      assign single = host ? ctrl_reg[`LUCA_F_RAIL + ch] : rail_mode_sel;
      assign aones  = host ? ctrl_reg[`LUCA_F_AONES + ch] : all_ones_select[ch];
      // loop pins ignored in host mode
      assign llb    = host ? ctrl_reg[`LUCA_F_LLB + ch] : local_loop_sel[ch];
      assign rlb    = host ? ctrl_reg[`LUCA_F_RLB + ch] : remote_loop_sel[ch];

      always_comb begin
         case ({llb, rlb})
            2'b10:   mode = LUCA_LOOP_ANALOG;
            2'b11:   mode = LUCA_LOOP_DIGITAL;
            2'b01:   mode = LUCA_LOOP_REMOTE;
            default: mode = LUCA_LOOP_NONE;
         endcase
      end

      luca_chan u_chan (
         .clk_sys     (clk_sys),
         .rst_n       (rst_n),
         .e3_mode     (e3_mode_sel[ch]),
         .thr_sel     (signal_threshold_sel),
         .single_rail (single),
         .all_ones    (aones),
         .loop_mode   (mode),
         .tx_clk_in   (tx_line_clock[ch]),
         .tx_pos_in   (tx_pos_data[ch]),
         .tx_neg_in   (tx_neg_data[ch]),
         .mon_tip     (monitor_tip_in[ch]),
         .mon_ring    (monitor_ring_in[ch]),
         .rx_clk_in   (rx_line_clock[ch]),
         .rx_pos_in   (rx_line_pos[ch]),
         .rx_neg_in   (rx_line_neg[ch]),
         .ref_clk_in  (reference_clock_in[ch]),
         .drive_fail  (dfail_w[ch]),
         .line_tip    (line_out_tip[ch]),
         .line_ring   (line_out_ring[ch]),
         .rx_pos_out  (rx_positive_rail[ch]),
         .rx_neg_out  (rx_negative_rail[ch]),
         .los         (los_w[ch]),
         .lol         (lol_w[ch]),
         .lcv_pulse   (lcv_w[ch])
      );
   end

   assign drive_fail_flag = dfail_w;
   assign signal_loss_out = los_w;
   assign lock_loss_out   = lol_w;

endmodule : luca_top
`default_nettype wire

// ---- tb/luca_top_props.sv ----
// Bus handshake, interrupt, tri-state and drive-monitor timing checks.
// Assumes one clock domain, clk_sys, and the active-low reset rst_n.
`timescale 1ns/1ps
`default_nettype none
module luca_top_props #(
   parameter int NCH = 4
) (
   input wire logic           clk_sys,
   input wire logic           rst_n,
   input wire logic           avs_read,
   input wire logic           avs_write,
   input wire logic [31:0]    avs_readdata,
   input wire logic           avs_waitrequest,
   input wire logic           irq,
   input wire logic           incircuit_test_n,
   input wire logic           pins_oe_n,
   input wire logic [NCH-1:0] monitor_tip_in,
   input wire logic [NCH-1:0] monitor_ring_in,
   input wire logic [NCH-1:0] drive_fail_flag
);
   // ****
   // Quiet-time counter, saturating, channel 0
   // ****
   logic [9:0] quiet_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) quiet_reg <= 10'h000;
      else if (monitor_tip_in[0] ^ monitor_ring_in[0]) quiet_reg <= 10'h000;
      else if (quiet_reg != 10'h3ff) quiet_reg <= quiet_reg + 10'h001;
   end
   property p_ack_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_soon; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ack_soon: assert property (p_ack_soon) else $error("request not answered");
   property p_rdata_hold; $changed(avs_readdata) |-> avs_read && !avs_waitrequest; endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_irq_fall; $fell(irq) |-> $past(avs_write) && !$past(avs_waitrequest); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_hiz; !incircuit_test_n |=> pins_oe_n; endproperty
   a_hiz: assert property (p_hiz) else $error("pins driven in test");
   property p_drive; $fell(pins_oe_n) |-> $past(incircuit_test_n); endproperty
   a_drive: assert property (p_drive) else $error("pins driven early");
   property p_dfail_clr; (monitor_tip_in[0] ^ monitor_ring_in[0]) |-> ##[1:3] !drive_fail_flag[0]; endproperty
   a_dfail_clr: assert property (p_dfail_clr) else $error("drive fail kept");
   property p_dfail_rise; $rose(drive_fail_flag[0]) |-> quiet_reg >= 10'd240; endproperty
   a_dfail_rise: assert property (p_dfail_rise) else $error("drive fail early");
endmodule : luca_top_props
bind luca_top luca_top_props #(.NCH(NCH)) u_props (.clk_sys, .rst_n, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .irq, .incircuit_test_n, .pins_oe_n, .monitor_tip_in,
   .monitor_ring_in, .drive_fail_flag);
`default_nettype wire

// ---- tb/luca_line_model.sv ----
// Framer and line model: clocks at clk_sys/4, random dual-rail data,
// monitor pins wired back from the line outputs; receive line silent.
`timescale 1ns/1ps
`default_nettype none
module luca_line_model (
   input wire logic  clk_sys,
   input wire logic  tx_zero,
   input wire logic  pins_oe_n,
   input wire logic  [3:0] line_out_tip,
   input wire logic  [3:0] line_out_ring,
   output logic      [3:0] tx_line_clock,
   output logic      [3:0] tx_pos_data,
   output logic      [3:0] tx_neg_data,
   output logic      [3:0] monitor_tip_in,
   output logic      [3:0] monitor_ring_in,
   output logic      [3:0] rx_line_clock,
   output logic      [3:0] rx_line_pos,
   output logic      [3:0] rx_line_neg,
   output logic      [3:0] reference_clock_in
);
   // ****
   // Shared clocks, data moves on the falling phase
   // ****
   logic [1:0] div_reg = 2'h0;
   logic [7:0] v;
   assign tx_line_clock = {4{div_reg[1]}};
   assign rx_line_clock = {4{div_reg[1]}};
   assign reference_clock_in = {4{div_reg[1]}};
   assign rx_line_pos = 4'h0;
   assign rx_line_neg = 4'h0;
   // pull-up when tri-stated, so no pulse is seen
   assign monitor_tip_in = pins_oe_n ? 4'hf : line_out_tip;
   assign monitor_ring_in = pins_oe_n ? 4'hf : line_out_ring;
   initial {tx_pos_data, tx_neg_data} = 8'h00;
   always @(posedge clk_sys) begin
      div_reg <= div_reg + 2'h1;
      v = tx_zero ? 8'h00 : 8'($urandom);
      if (div_reg == 2'h3) tx_pos_data <= v[3:0];
      if (div_reg == 2'h3) tx_neg_data <= v[7:4] & ~v[3:0];
   end
endmodule : luca_line_model
`default_nettype wire

// ---- tb/luca_top_tb.sv ----
// Self-checking bench of the line unit: registers, alarms, loop-backs.
// Assumes luca_line_model as far side and the bound property checker.
`timescale 1ns/1ps
`default_nettype none
module luca_top_tb;
   import luca_pkg::*;
   logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, tx_zero = 0;
   logic select_a = 0, incircuit_test_n = 1, signal_threshold_sel = 0, rail_mode_sel = 0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h3, e3_mode_sel = 4'h0;
   logic [3:0] all_ones_select = 4'h0, local_loop_sel = 4'h0, remote_loop_sel = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, irq, pins_oe_n;
   logic [3:0] tx_line_clock, tx_pos_data, tx_neg_data, monitor_tip_in, monitor_ring_in, rx_line_clock;
   logic [3:0] rx_line_pos, rx_line_neg, reference_clock_in, line_out_tip, line_out_ring;
   logic [3:0] rx_positive_rail, rx_negative_rail, drive_fail_flag, signal_loss_out, lock_loss_out;
   int compares = 0, miscompares = 0, cyc = 0, nrx, ntx;
   // Every port meets the bench signal of the same name
   luca_top dut (.*);
   luca_line_model u_line (.*);
   // ****
   // Clock, timeout, bus and compare helpers
   // ****
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0 && cyc < 20000);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   // Expected {receive active, line active, loss} per loop select pair
   function automatic logic [2:0] loop_exp(input logic l, input logic r);
      return {l, l | !r, !l};
   endfunction : loop_exp
   task final_report;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // ****
   // Main sequence
   // ****
   initial begin
      void'($urandom(32'h0e7a));
      @(posedge clk_sys);
      // strap set once before reset, never changed
      signal_threshold_sel <= 1'($urandom);
      e3_mode_sel <= 4'($urandom);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      incircuit_test_n <= 1'b0;
      idle(3);
      chk(pins_oe_n, 1'b1);
      incircuit_test_n <= 1'b1;
      idle(3);
      chk(pins_oe_n, 1'b0);
      bus(0, 4'h0, 0); chk(rd, 32'h0); bus(0, 4'h8, 0); chk(rd, 32'h0); bus(0, 4'h2, 0); chk(rd, 32'h0);
      $display("test registers done");
      tx_zero <= 1'b1;
      all_ones_select <= 4'h1;
      idle(380);
      chk(drive_fail_flag, 4'h0);
      idle(400);
      chk(drive_fail_flag, 4'he);
      bus(0, 4'h4, 0);
      chk(rd & 32'hf, 32'he);
      bus(1, 4'h8, 32'h2); idle(2); chk(irq, 1'b1);
      bus(1, 4'h4, 32'h2); idle(2); chk(irq, 1'b0);
      select_a <= 1'b1;
      idle(800);
      chk(drive_fail_flag, 4'hf);
      bus(1, 4'h0, 32'h10); idle(20); chk(drive_fail_flag, 4'he);
      bus(0, 4'hc, 0); chk(rd[16], 1'b1);
      bus(1, 4'h0, 0);
      select_a <= 1'b0;
      all_ones_select <= 4'h0;
      tx_zero <= 1'b0;
      $display("test drive monitor done");
      for (int i = 0; i < 4; i++) begin
         local_loop_sel <= {3'h0, i[0]};
         remote_loop_sel <= {3'h0, i[1]};
         idle(800);
         nrx = 0;
         ntx = 0;
         repeat (200) begin
            @(posedge clk_sys);
            nrx += int'(rx_positive_rail[0] | rx_negative_rail[0]);
            ntx += int'(line_out_tip[0] | line_out_ring[0]);
         end
         chk({nrx != 0, ntx != 0, signal_loss_out[0]}, loop_exp(i[0], i[1]));
         chk(lock_loss_out[0], 1'b0);
      end
      $display("test loops done");
      final_report();
   end
endmodule : luca_top_tb
`default_nettype wire
